/* File: core/bridge_blender.sv */
// Per-pulse choice between half and full bridge for hybrid speed
`timescale 1ns/1ps
module bridge_blender (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       enable,
  input  wire logic       pulse_tick,
  input  wire logic [7:0] blend_value,
  output logic            use_full
);
  import piezo_pkg::*;

  typedef struct packed {
    logic [7:0] acc;
    logic       full;
  } blend_s;

  blend_s     s_reg;
  blend_s     s_next;
  logic [8:0] sum;

  // Error accumulation spreads full-bridge pulses evenly, ratio value/128
  always_comb begin
    s_next = s_reg;
    sum    = {1'b0, s_reg.acc} + {1'b0, blend_limit(blend_value)};
    if (!enable) begin
      s_next.acc  = 8'h00;
      s_next.full = 1'b1;
    end else if (pulse_tick) begin
      if (sum >= {1'b0, BLEND_FULL}) begin
        s_next.acc  = 8'(sum - {1'b0, BLEND_FULL});
        s_next.full = 1'b1;
      end else begin
        s_next.acc  = sum[7:0];
        s_next.full = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_reg <= '{acc: 8'h00, full: 1'b1};
    end else begin
      s_reg <= s_next;
    end
  end

  assign use_full = s_reg.full;

  a_blend_half: assert property (@(posedge mclk) disable iff (rst)
    enable && pulse_tick && blend_value == 8'h00 |=> !use_full)
    else $error("blend zero must give half bridge");
  a_blend_full: assert property (@(posedge mclk) disable iff (rst)
    enable && pulse_tick && blend_value >= BLEND_FULL |=> use_full)
    else $error("blend 128 must give full bridge");

endmodule

/* File: core/piezo_drive_register_bank.sv */
// Register bank of the piezo motor driver and its derived drive settings
// Summary of operation
// - Registers at bytes 00h to 07h, all reachable through the register port.
// - High count byte bit 7 is period bit 8; bit 6 is direction.
// - Dead-time select codes 00,01,10,11 give 2,4,6,8 VCO clocks.
// - Period offset applies only while calibrate-now holds 00.
// - Running frequency tracking suppresses the period offset completely.
// - Offset register top bit requests idle mode.
// - Half-bridge bit gives half bridge only above supply threshold.
// - Hybrid bit enables alternating half and full bridge drive.
// - Dead-time extend bit enables the longer selected dead time.
// - Dead-time select ignored unless the extend bit is one.
// - Blend 0 is half bridge, 128 full bridge, linear between.
// - Bridge blend register resets to 128, full bridge.
// - Factory test register at 10h refused outside test mode.
// - Pulse count write starts counting pulses; zero stops, outputs low.
// - Calibrate-now 00 none, 01 incremental, 10 sweep, 11 reserved.
// - Sense select 00 none, 01 phase one, 10 phase two, 11 both.
// - High count byte bit 6 sets motor direction.
`timescale 1ns/1ps
module piezo_drive_register_bank (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire piezo_pkg::reg_req_s   req,
  output piezo_pkg::reg_rsp_s        rsp,
  input  wire logic                  test_enable,
  input  wire logic                  supply_above_hb,
  input  wire logic                  tracking_busy,
  input  wire logic                  pulse_tick,
  output piezo_pkg::drive_cfg_s      cfg,
  output logic [10:0]                pulses_remaining
);
  import piezo_pkg::*;

  typedef struct packed {
    logic [7:0] drive_control;
    logic [7:0] drive_period_low;
    logic [7:0] pulse_count_high;
    logic [7:0] pulse_count_low;
    logic [7:0] duty_cycle;
    logic [7:0] phase_delay;
    logic [7:0] frequency_offset_modes;
    logic [7:0] bridge_blend;
    logic [7:0] factory_test;
    reg_rsp_s   rsp;
    drive_cfg_s cfg;
  } bank_s;

  bank_s       s_reg;
  bank_s       s_next;
  logic        access;
  logic        mapped;
  logic        refused;
  logic        do_write;
  logic        count_load;
  logic [10:0] count_value;
  logic        counter_running;
  logic [10:0] counter_remaining;
  logic        blend_full;
  logic        offset_apply;
  logic [8:0]  base_period;
  logic [7:0]  read_value;

  function automatic logic addr_mapped(input logic [7:0] a);
    return (a <= ADDR_BRIDGE_BLEND) || (a == ADDR_FACTORY_TEST);
  endfunction

  // Eleven-bit pulse count from the two count bytes
  function automatic logic [10:0] pulse_count_of(input logic [7:0] hi, input logic [7:0] lo);
    return {hi[HI_COUNT_MSB:0], lo};
  endfunction

  // Address decode and refusal
  always_comb begin
    access   = req.wr | req.rd;
    mapped   = addr_mapped(req.addr);
    refused  = access && (!mapped || (req.addr == ADDR_FACTORY_TEST && !test_enable));
    do_write = req.wr && !refused;
  end

  // Counter reload on either count byte, so a page write lands both halves
  always_comb begin
    count_load  = do_write && (req.addr == ADDR_PULSE_COUNT_HI || req.addr == ADDR_PULSE_COUNT_LO);
    count_value = pulse_count_of(s_next.pulse_count_high, s_next.pulse_count_low);
  end

  always_comb begin
    read_value = 8'h00;
    unique case (req.addr)
      ADDR_DRIVE_CONTROL:   read_value = s_reg.drive_control;
      ADDR_DRIVE_PERIOD_LO: read_value = s_reg.drive_period_low;
      ADDR_PULSE_COUNT_HI:  read_value = s_reg.pulse_count_high;
      ADDR_PULSE_COUNT_LO:  read_value = s_reg.pulse_count_low;
      ADDR_DUTY_CYCLE:      read_value = s_reg.duty_cycle;
      ADDR_PHASE_DELAY:     read_value = s_reg.phase_delay;
      ADDR_FREQ_OFFSET:     read_value = s_reg.frequency_offset_modes;
      ADDR_BRIDGE_BLEND:    read_value = s_reg.bridge_blend;
      ADDR_FACTORY_TEST:    read_value = s_reg.factory_test;
      default:              read_value = 8'h00;
    endcase
  end

  always_comb begin
    s_next = s_reg;
    s_next.rsp.ack     = access;
    s_next.rsp.refused = refused;
    s_next.rsp.rdata   = 8'h00;
    if (req.rd && !req.wr && !refused) begin
      s_next.rsp.rdata = read_value;
    end
    if (do_write) begin
      unique case (req.addr)
        ADDR_DRIVE_CONTROL:   s_next.drive_control = req.wdata & MASK_DRIVE_CONTROL;
        ADDR_DRIVE_PERIOD_LO: s_next.drive_period_low = req.wdata;
        ADDR_PULSE_COUNT_HI:  s_next.pulse_count_high = req.wdata & MASK_COUNT_HI;
        ADDR_PULSE_COUNT_LO:  s_next.pulse_count_low = req.wdata;
        ADDR_DUTY_CYCLE:      s_next.duty_cycle = req.wdata;
        ADDR_PHASE_DELAY:     s_next.phase_delay = req.wdata;
        ADDR_FREQ_OFFSET:     s_next.frequency_offset_modes = req.wdata & MASK_FREQ_OFFSET;
        ADDR_BRIDGE_BLEND:    s_next.bridge_blend = req.wdata;
        ADDR_FACTORY_TEST:    s_next.factory_test = req.wdata;
        default: begin
        end
      endcase
    end
    // Derived drive settings, taken from the next register values so they move with the ack
    base_period  = {s_next.pulse_count_high[HI_PERIOD_MSB], s_next.drive_period_low};
    offset_apply = (s_next.drive_control[CTRL_CAL_LSB +: 2] == CAL_NONE)
                   && !tracking_busy;
    s_next.cfg.period = {1'b0, base_period};
    if (offset_apply) begin
      s_next.cfg.period = {1'b0, base_period}
                          + {7'h00, s_next.frequency_offset_modes[OFS_VALUE_MSB:0]};
    end
    s_next.cfg.direction = s_next.pulse_count_high[HI_DIRECTION];
    // Select changes mid-drive glitch the dead time; host keeps it static while active
    s_next.cfg.dead_time = dead_time_clocks(s_next.frequency_offset_modes[OFS_DEAD_EXTEND],
                                            s_next.pulse_count_high[HI_DEAD_SEL_LSB +: 2]);
    s_next.cfg.duty        = s_next.duty_cycle;
    s_next.cfg.phase_delay = s_next.phase_delay;
    s_next.cfg.idle        = s_next.frequency_offset_modes[OFS_IDLE];
    if (s_next.frequency_offset_modes[OFS_HALF_BRIDGE]) begin
      s_next.cfg.half_bridge = supply_above_hb;
    end else if (s_next.frequency_offset_modes[OFS_BLEND]) begin
      s_next.cfg.half_bridge = !blend_full;
    end else begin
      s_next.cfg.half_bridge = 1'b0;
    end
    s_next.cfg.phase_one_enable   = s_next.drive_control[CTRL_PHASE_ONE];
    s_next.cfg.phase_two_enable   = s_next.drive_control[CTRL_PHASE_TWO];
    s_next.cfg.sense_phase_select = sense_e'(s_next.drive_control[CTRL_SENSE_LSB +: 2]);
    s_next.cfg.calibrate_now      = cal_mode_e'(s_next.drive_control[CTRL_CAL_LSB +: 2]);
    if (s_next.drive_control[CTRL_CAL_LSB +: 2] == CAL_RESERVED) begin
      s_next.cfg.calibrate_now = CAL_NONE;
    end
    s_next.cfg.run         = counter_running && !s_next.frequency_offset_modes[OFS_IDLE];
    s_next.cfg.outputs_low = !counter_running;
    if (count_load && pulse_count_of(s_next.pulse_count_high, s_next.pulse_count_low) == 11'h000) begin
      s_next.cfg.run         = 1'b0;
      s_next.cfg.outputs_low = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.drive_control         <= RST_DRIVE_CONTROL;
      s_reg.drive_period_low      <= RST_ZERO;
      s_reg.pulse_count_high      <= RST_ZERO;
      s_reg.pulse_count_low       <= RST_ZERO;
      s_reg.duty_cycle            <= RST_ZERO;
      s_reg.phase_delay           <= RST_ZERO;
      s_reg.frequency_offset_modes <= RST_ZERO;
      s_reg.bridge_blend          <= RST_BRIDGE_BLEND;
      s_reg.factory_test          <= RST_ZERO;
      s_reg.cfg.dead_time         <= DEAD_TIME_BASE;
      s_reg.cfg.phase_one_enable  <= 1'b1;
      s_reg.cfg.phase_two_enable  <= 1'b1;
      s_reg.cfg.sense_phase_select <= SENSE_BOTH;
      s_reg.cfg.outputs_low       <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  pulse_counter pulse_counter_i (
    .mclk       (mclk),
    .rst        (rst),
    .load       (count_load),
    .load_value (count_value),
    .pulse_tick (pulse_tick),
    .running    (counter_running),
    .remaining  (counter_remaining)
  );

  bridge_blender bridge_blender_i (
    .mclk        (mclk),
    .rst         (rst),
    .enable      (s_reg.frequency_offset_modes[OFS_BLEND]),
    .pulse_tick  (pulse_tick),
    .blend_value (s_reg.bridge_blend),
    .use_full    (blend_full)
  );

  assign rsp              = s_reg.rsp;
  assign cfg              = s_reg.cfg;
  assign pulses_remaining = counter_remaining;

  sequence write_to(logic [7:0] a);
    req.wr && req.addr == a && !refused;
  endsequence

  sequence blend_readback;
    req.rd && !req.wr && req.addr == ADDR_BRIDGE_BLEND;
  endsequence

  // Zero count stops the drive in the ack cycle, not a cycle later
  sequence zero_count_load;
    count_load && count_value == 11'h000;
  endsequence

  a_blend_reset: assert property (@(posedge mclk)
    rst |=> s_reg.bridge_blend == RST_BRIDGE_BLEND)
    else $error("bridge blend did not reset to 128");
  a_blend_readback: assert property (@(posedge mclk) disable iff (rst)
    blend_readback |=> rsp.ack && rsp.rdata == $past(s_reg.bridge_blend))
    else $error("bridge blend read back wrong value");
  a_test_refused: assert property (@(posedge mclk) disable iff (rst)
    access && req.addr == ADDR_FACTORY_TEST && !test_enable |=> rsp.ack && rsp.refused && rsp.rdata == 8'h00)
    else $error("factory test access was not refused");
  a_mapped_ack: assert property (@(posedge mclk) disable iff (rst)
    access && req.addr <= ADDR_BRIDGE_BLEND |=> rsp.ack && !rsp.refused)
    else $error("mapped register access refused");
  a_dead_time_map: assert property (@(posedge mclk) disable iff (rst)
    write_to(ADDR_PULSE_COUNT_HI) ##0 s_reg.frequency_offset_modes[OFS_DEAD_EXTEND]
    |=> cfg.dead_time == 4'(2 * ($past(req.wdata[5:4]) + 1)))
    else $error("dead time does not match select code");
  a_dead_time_base: assert property (@(posedge mclk) disable iff (rst)
    !s_reg.frequency_offset_modes[OFS_DEAD_EXTEND] |-> cfg.dead_time == DEAD_TIME_BASE)
    else $error("dead time select acted without extend bit");
  a_offset_gated: assert property (@(posedge mclk) disable iff (rst)
    ##1 ($past(tracking_busy) || s_reg.drive_control[3:2] != 2'b00)
    |-> cfg.period == {1'b0, s_reg.pulse_count_high[7], s_reg.drive_period_low})
    else $error("period offset applied during calibration or tracking");
  a_offset_added: assert property (@(posedge mclk) disable iff (rst)
    ##1 (!$past(tracking_busy) && s_reg.drive_control[3:2] == 2'b00)
    |-> cfg.period == {1'b0, s_reg.pulse_count_high[7], s_reg.drive_period_low}
                      + {7'h00, s_reg.frequency_offset_modes[2:0]})
    else $error("period offset missing when it should apply");
  a_half_bridge: assert property (@(posedge mclk) disable iff (rst)
    s_next.frequency_offset_modes[OFS_HALF_BRIDGE] |=> cfg.half_bridge == $past(supply_above_hb))
    else $error("half bridge does not follow supply threshold");
  a_idle_bit: assert property (@(posedge mclk) disable iff (rst)
    s_reg.frequency_offset_modes[OFS_IDLE] |-> cfg.idle && !cfg.run)
    else $error("idle bit did not idle the drive");
  a_zero_count_low: assert property (@(posedge mclk) disable iff (rst)
    zero_count_load |=> (cfg.outputs_low && !cfg.run) [*2])
    else $error("zero pulse count did not pull outputs low");
  a_count_pairs: assert property (@(posedge mclk) disable iff (rst)
    count_load |=> pulses_remaining == $past(count_value))
    else $error("pulse count bytes not paired into counter");

  // Register port answers
  a_ack_single: assert property (@(posedge mclk) disable iff (rst)
    !access |=> !rsp.ack)
    else $error("ack without a request");
  a_unmapped_refused: assert property (@(posedge mclk) disable iff (rst)
    access && !addr_mapped(req.addr) |=> rsp.ack && rsp.refused && rsp.rdata == 8'h00)
    else $error("unmapped address not refused");
  a_refused_no_write: assert property (@(posedge mclk) disable iff (rst)
    req.wr && refused |=> s_reg.factory_test == $past(s_reg.factory_test))
    else $error("refused write changed the test register");
  a_write_lands: assert property (@(posedge mclk) disable iff (rst)
    write_to(ADDR_DUTY_CYCLE) |=> cfg.duty == $past(req.wdata))
    else $error("duty write did not reach the drive settings");

  // Field decode into the drive settings
  a_direction_bit: assert property (@(posedge mclk) disable iff (rst)
    cfg.direction == s_reg.pulse_count_high[HI_DIRECTION])
    else $error("direction does not follow count high bit 6");
  a_cal_decode: assert property (@(posedge mclk) disable iff (rst)
    s_reg.drive_control[3:2] != 2'b11 |-> cfg.calibrate_now == s_reg.drive_control[3:2])
    else $error("calibrate mode decoded wrongly");
  a_cal_reserved: assert property (@(posedge mclk) disable iff (rst)
    s_reg.drive_control[3:2] == 2'b11 |-> cfg.calibrate_now == CAL_NONE)
    else $error("reserved calibrate code started a calibration");
  a_sense_decode: assert property (@(posedge mclk) disable iff (rst)
    cfg.sense_phase_select == s_reg.drive_control[6:5])
    else $error("sense select decoded wrongly");
  a_phase_enables: assert property (@(posedge mclk) disable iff (rst)
    {cfg.phase_one_enable, cfg.phase_two_enable} == s_reg.drive_control[1:0])
    else $error("phase enables do not follow control bits");
  a_dead_time_range: assert property (@(posedge mclk) disable iff (rst)
    cfg.dead_time inside {4'h2, 4'h4, 4'h6, 4'h8})
    else $error("dead time outside 2 to 8 clocks");
  a_full_default: assert property (@(posedge mclk) disable iff (rst)
    !s_reg.frequency_offset_modes[OFS_HALF_BRIDGE] && !s_reg.frequency_offset_modes[OFS_BLEND]
    |-> !cfg.half_bridge)
    else $error("half bridge without half bridge or hybrid bit");
  a_hybrid_blend: assert property (@(posedge mclk) disable iff (rst)
    !s_next.frequency_offset_modes[OFS_HALF_BRIDGE] && s_next.frequency_offset_modes[OFS_BLEND]
    |=> cfg.half_bridge == !$past(blend_full))
    else $error("hybrid drive does not follow the blender");

endmodule

/* File: core/piezo_pkg.sv */
// Shared constants, types and helpers for the piezo drive register bank
package piezo_pkg;

  localparam logic [7:0] ADDR_DRIVE_CONTROL   = 8'h00;
  localparam logic [7:0] ADDR_DRIVE_PERIOD_LO = 8'h01;
  localparam logic [7:0] ADDR_PULSE_COUNT_HI  = 8'h02;
  localparam logic [7:0] ADDR_PULSE_COUNT_LO  = 8'h03;
  localparam logic [7:0] ADDR_DUTY_CYCLE      = 8'h04;
  localparam logic [7:0] ADDR_PHASE_DELAY     = 8'h05;
  localparam logic [7:0] ADDR_FREQ_OFFSET     = 8'h06;
  localparam logic [7:0] ADDR_BRIDGE_BLEND    = 8'h07;
  localparam logic [7:0] ADDR_FACTORY_TEST    = 8'h10;

  localparam logic [7:0] RST_DRIVE_CONTROL = 8'h63;
  localparam logic [7:0] RST_ZERO          = 8'h00;
  localparam logic [7:0] RST_BRIDGE_BLEND  = 8'h80;

  // Reserved bits are held at zero by masking writes
  localparam logic [7:0] MASK_DRIVE_CONTROL = 8'h6f;
  localparam logic [7:0] MASK_COUNT_HI      = 8'hf7;
  localparam logic [7:0] MASK_FREQ_OFFSET   = 8'hf7;

  localparam int CTRL_SENSE_LSB   = 5;
  localparam int CTRL_CAL_LSB     = 2;
  localparam int CTRL_PHASE_ONE   = 1;
  localparam int CTRL_PHASE_TWO   = 0;
  localparam int HI_PERIOD_MSB    = 7;
  localparam int HI_DIRECTION     = 6;
  localparam int HI_DEAD_SEL_LSB  = 4;
  localparam int HI_COUNT_MSB     = 2;
  localparam int OFS_IDLE         = 7;
  localparam int OFS_HALF_BRIDGE  = 6;
  localparam int OFS_BLEND        = 5;
  localparam int OFS_DEAD_EXTEND  = 4;
  localparam int OFS_VALUE_MSB    = 2;

  localparam logic [3:0] DEAD_TIME_BASE  = 4'h2;
  localparam logic [7:0] BLEND_FULL      = 8'h80;

  typedef enum logic [1:0] {
    CAL_NONE        = 2'b00,
    CAL_INCREMENTAL = 2'b01,
    CAL_SWEEP       = 2'b10,
    CAL_RESERVED    = 2'b11
  } cal_mode_e;

  typedef enum logic [1:0] {
    SENSE_NONE      = 2'b00,
    SENSE_PHASE_ONE = 2'b01,
    SENSE_PHASE_TWO = 2'b10,
    SENSE_BOTH      = 2'b11
  } sense_e;

  typedef enum logic [1:0] {
    CNT_OFF  = 2'b00,
    CNT_RUN  = 2'b01,
    CNT_LAST = 2'b11
  } count_state_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic       ack;
    logic       refused;
    logic [7:0] rdata;
  } reg_rsp_s;

  typedef struct packed {
    logic [9:0] period;
    logic       direction;
    logic [3:0] dead_time;
    logic [7:0] duty;
    logic [7:0] phase_delay;
    logic       idle;
    logic       half_bridge;
    logic       phase_one_enable;
    logic       phase_two_enable;
    sense_e     sense_phase_select;
    cal_mode_e  calibrate_now;
    logic       run;
    logic       outputs_low;
  } drive_cfg_s;

  // Dead time in VCO clocks: base unless extended, then 2/4/6/8
  function automatic logic [3:0] dead_time_clocks(input logic extend, input logic [1:0] sel);
    logic [3:0] n;
    n = DEAD_TIME_BASE;
    if (extend) begin
      n = {1'b0, sel, 1'b0} + DEAD_TIME_BASE;
    end
    return n;
  endfunction

  // Values above full bridge saturate to full bridge
  function automatic logic [7:0] blend_limit(input logic [7:0] v);
    return (v > BLEND_FULL) ? BLEND_FULL : v;
  endfunction

endpackage

/* File: core/pulse_counter.sv */
// Counter of remaining drive pulses, loaded by a pulse count write
`timescale 1ns/1ps
module pulse_counter (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        load,
  input  wire logic [10:0] load_value,
  input  wire logic        pulse_tick,
  output logic             running,
  output logic [10:0]      remaining
);
  import piezo_pkg::*;

  typedef struct packed {
    count_state_e st;
    logic [10:0]  rem;
  } counter_s;

  counter_s s_reg;
  counter_s s_next;

  always_comb begin
    s_next = s_reg;
    if (load) begin
      s_next.rem = load_value;
      if (load_value == 11'h000) begin
        s_next.st = CNT_OFF;
      end else if (load_value == 11'h001) begin
        s_next.st = CNT_LAST;
      end else begin
        s_next.st = CNT_RUN;
      end
    end else if (pulse_tick) begin
      unique case (s_reg.st)
        CNT_OFF: begin
        end
        CNT_RUN: begin
          s_next.rem = s_reg.rem - 11'h001;
          if (s_reg.rem == 11'h002) begin
            s_next.st = CNT_LAST;
          end
        end
        CNT_LAST: begin
          s_next.rem = 11'h000;
          s_next.st  = CNT_OFF;
        end
        default: begin
          s_next.st = CNT_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign running   = (s_reg.st != CNT_OFF);
  assign remaining = s_reg.rem;

  a_zero_stops: assert property (@(posedge mclk) disable iff (rst)
    load && load_value == 11'h000 |=> !running && remaining == 11'h000)
    else $error("zero pulse count did not stop the counter");
  a_load_starts: assert property (@(posedge mclk) disable iff (rst)
    load && load_value != 11'h000 |=> running && remaining == $past(load_value))
    else $error("pulse count load did not start the counter");
  a_tick_counts: assert property (@(posedge mclk) disable iff (rst)
    !load && pulse_tick && remaining > 11'h001 |=> remaining == $past(remaining) - 11'h001)
    else $error("pulse tick did not decrement remaining count");

endmodule

/* File: sim/reg_host_model.sv */
// Host model that issues accesses on the register port
`timescale 1ns/1ps
module reg_host_model
  import piezo_pkg::*;
(
  input  wire logic                mclk,
  output piezo_pkg::reg_req_s      req,
  input  wire piezo_pkg::reg_rsp_s rsp
);
  initial begin
    req = '0;
  end

  // Request held over one taking edge; answer read in the following cycle
  task automatic access(input int gap, input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                        output logic ack, output logic refused, output logic [7:0] rdata);
    repeat (gap + 1) @(negedge mclk);
    req <= '{wr: wr, rd: !wr, addr: addr, wdata: wdata};
    @(negedge mclk);
    ack = rsp.ack;
    refused = rsp.refused;
    rdata = rsp.rdata;
    req <= '0;
  endtask
endmodule

/* File: sim/tb_piezo_drive_register_bank.sv */
// Self-checking bench for the piezo drive register bank
`timescale 1ns/1ps
module tb_piezo_drive_register_bank;
  import piezo_pkg::*;
  logic       mclk;
  logic       rst;
  reg_req_s   req;
  reg_rsp_s   rsp;
  logic       test_enable;
  logic       supply_above_hb;
  logic       tracking_busy;
  logic       pulse_tick;
  drive_cfg_s cfg;
  logic [10:0] pulses_remaining;
  int         num_errors;
  int         cmp_count;
  int         cycles;
  int         n;

  piezo_drive_register_bank piezo_drive_register_bank_i (
    .mclk(mclk), .rst(rst), .req(req), .rsp(rsp), .test_enable(test_enable),
    .supply_above_hb(supply_above_hb), .tracking_busy(tracking_busy), .pulse_tick(pulse_tick),
    .cfg(cfg), .pulses_remaining(pulses_remaining)
  );
  reg_host_model reg_host_model_i (.mclk(mclk), .req(req), .rsp(rsp));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic final_report();
    $display("Comparisons %0d, errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Hang guard; the full sequence needs well under two thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 8000) begin
      num_errors++;
      final_report();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic refd = 1'b0);
    logic ack, rf;
    logic [7:0] rd;
    reg_host_model_i.access(a[0], 1'b1, a, d, ack, rf, rd);
    check("write ack/refused", {ack, rf}, {1'b1, refd});
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic refd = 1'b0);
    logic ack, rf;
    logic [7:0] d;
    reg_host_model_i.access(0, 1'b0, a, 8'h00, ack, rf, d);
    check("read ack/refused", {ack, rf}, {1'b1, refd});
    check("read data", d, exp);
  endtask

  task automatic settle();
    repeat (3) @(negedge mclk);
  endtask

  task automatic tick();
    @(negedge mclk);
    pulse_tick = 1'b1;
    @(negedge mclk);
    pulse_tick = 1'b0;
    repeat (2) @(negedge mclk);
  endtask

  initial begin
    rst = 1'b1;
    test_enable = 1'b0;
    supply_above_hb = 1'b0;
    tracking_busy = 1'b0;
    pulse_tick = 1'b0;
    repeat (8) @(negedge mclk);
    rst = 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd(i[7:0], (i == 0) ? 8'h63 : (i == 7) ? 8'h80 : 8'h00);
    end
    check("reset dead time", cfg.dead_time, 4'h2);
    for (int i = 1; i < 8; i++) begin
      wr(i[7:0], 8'ha3 ^ i[7:0]);
      rd(i[7:0], (8'ha3 ^ i[7:0]) & ((i == 2 || i == 6) ? 8'hf7 : 8'hff));
    end
    check("duty and phase", {cfg.duty, cfg.phase_delay}, {8'ha7, 8'ha6});
    wr(8'h00, 8'hff);
    rd(8'h00, 8'h6f);
    wr(8'h00, 8'h60);
    wr(8'h01, 8'h94);
    wr(8'h03, 8'h00);
    for (int s = 0; s < 4; s++) begin
      wr(8'h02, {2'b10, s[1:0], 4'h0});
      wr(8'h06, 8'h00);
      settle();
      check("dead time plain", cfg.dead_time, 4'h2);
      wr(8'h06, 8'h10);
      settle();
      check("dead time extended", cfg.dead_time, 4'h2 + 4'(2 * s));
    end
    check("direction", cfg.direction, 1'b0);
    wr(8'h06, 8'h03);
    settle();
    check("period with offset", cfg.period, 10'h197);
    tracking_busy = 1'b1;
    settle();
    check("period while tracking", cfg.period, 10'h194);
    tracking_busy = 1'b0;
    for (int c = 0; c < 4; c++) begin
      wr(8'h00, {3'b011, 1'b0, c[1:0], 2'b11});
      settle();
      check("calibrate mode", cfg.calibrate_now, (c == 3) ? 2'b00 : c[1:0]);
      if (c < 3) begin
        check("period by cal mode", cfg.period, (c == 0) ? 10'h197 : 10'h194);
      end
    end
    for (int p = 0; p < 4; p++) begin
      wr(8'h00, {1'b0, p[1:0], 3'b000, p[1:0]});
      settle();
      check("sense select", cfg.sense_phase_select, p[1:0]);
      check("phase enables", {cfg.phase_one_enable, cfg.phase_two_enable}, p[1:0]);
    end
    wr(8'h06, 8'h80);
    settle();
    check("idle", {cfg.idle, cfg.run}, 2'b10);
    wr(8'h06, 8'h40);
    supply_above_hb = 1'b1;
    settle();
    check("half bridge high supply", cfg.half_bridge, 1'b1);
    supply_above_hb = 1'b0;
    settle();
    check("half bridge low supply", cfg.half_bridge, 1'b0);
    for (int b = 0; b < 3; b++) begin
      wr(8'h06, 8'h00);
      wr(8'h07, 8'(64 * b));
      wr(8'h06, 8'h20);
      n = 0;
      for (int t = 0; t < 8; t++) begin
        tick();
        n += (cfg.half_bridge === 1'b1);
      end
      check("half bridge pulses", 16'(n), 16'(8 - 4 * b));
    end
    wr(8'h06, 8'h00);
    wr(8'h02, 8'h40);
    wr(8'h03, 8'h03);
    settle();
    check("count loaded", pulses_remaining, 11'h003);
    check("running", {cfg.run, cfg.outputs_low, cfg.direction}, 3'b101);
    repeat (3) tick();
    check("count done", {pulses_remaining, cfg.outputs_low}, {11'h000, 1'b1});
    wr(8'h02, 8'h07);
    wr(8'h03, 8'hff);
    check("max count", pulses_remaining, 11'h7ff);
    wr(8'h06, 8'h80);
    check("idle stops run", {cfg.idle, cfg.run, pulses_remaining}, {2'b10, 11'h7ff});
    wr(8'h06, 8'h00);
    check("run after idle", cfg.run, 1'b1);
    wr(8'h02, 8'h00);
    check("low byte still counts", pulses_remaining, 11'h0ff);
    wr(8'h03, 8'h00);
    check("stop at once", {cfg.outputs_low, cfg.run, pulses_remaining}, {2'b10, 11'h000});
    rd(8'h08, 8'h00, 1'b1);
    wr(8'h10, 8'h5a, 1'b1);
    test_enable = 1'b1;
    rd(8'h10, 8'h00);
    wr(8'h10, 8'h5a);
    rd(8'h10, 8'h5a);
    test_enable = 1'b0;
    rd(8'h10, 8'h00, 1'b1);
    final_report();
  end
endmodule
